// file: design/dwsp_port.sv
`timescale 1ns/10ps

// ****************************************
// small synchronous fifo
// ****************************************
module dwsp_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH]; // storage words
   logic [AW-1:0] wr_q; // write pointer
   logic [AW-1:0] rd_q; // read pointer
   logic [AW:0] cnt_q; // words held
   logic push; // word taken this cycle
   logic pop; // word given this cycle

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointer wrap shared by both ends
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // storage, no reset needed on data
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= bump(wr_q);
         end
         if (pop) begin
            rd_q <= bump(rd_q);
         end
         // simultaneous push and pop leaves count alone
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ****************************************
// serial port, wiper latches, nv control
// ****************************************
module dwsp_port
   import dwsp_pkg::*;
#(
   parameter int SAVE_LEN = SAVE_CYCLES
) (
   // system clock and reset
   input wire logic clock,
   input wire logic resetn,
   // three-wire serial pins
   input wire logic port_enable,
   input wire logic port_clock,
   input wire logic port_data,
   output logic chain_data_output_q,
   output logic port_ready_q,
   // wiper multiplexer controls
   output logic [dwsp_pkg::CODE_W-1:0] wiper_code_zero_q,
   output logic [dwsp_pkg::CODE_W-1:0] wiper_code_one_q,
   output logic stack_select_q,
   output logic [dwsp_pkg::CODE_W-1:0] stacked_code_q,
   // supply monitor and nonvolatile copy
   input wire logic supply_low,
   input wire logic [dwsp_pkg::SHIFT_LEN-1:0] nv_read_data,
   output logic nv_write_en_q,
   output logic [dwsp_pkg::SHIFT_LEN-1:0] nv_write_data_q
);
   import dwsp_pkg::*;

   // ****************************************
   // pin synchronisers and edge finding
   // ****************************************
   logic en_s1_q, en_s2_q, en_d_q; // enable sync and history
   logic ck_s1_q, ck_s2_q, ck_d_q; // port clock sync and history
   logic dt_s1_q, dt_s2_q; // data sync
   logic lo_s1_q, lo_s2_q, lo_d_q; // supply low sync and history
   logic en_rise, en_fall, ck_rise, lo_rise; // one-cycle events

   // two flops per pin, plus history on all but data; first read only by second
   always_ff @(posedge clock) begin
      if (!resetn) begin
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         dt_s1_q <= 1'b0;
         dt_s2_q <= 1'b0;
         lo_s1_q <= 1'b0;
         lo_s2_q <= 1'b0;
         en_d_q <= 1'b0;
         ck_d_q <= 1'b0;
         lo_d_q <= 1'b0;
      end else begin
         en_s1_q <= port_enable;
         en_s2_q <= en_s1_q;
         ck_s1_q <= port_clock;
         ck_s2_q <= ck_s1_q;
         dt_s1_q <= port_data;
         dt_s2_q <= dt_s1_q;
         lo_s1_q <= supply_low;
         lo_s2_q <= lo_s1_q;
         en_d_q <= en_s2_q;
         ck_d_q <= ck_s2_q;
         lo_d_q <= lo_s2_q;
      end
   end

   assign en_rise = en_s2_q & ~en_d_q;
   assign en_fall = ~en_s2_q & en_d_q;
   assign ck_rise = ck_s2_q & ~ck_d_q;
   assign lo_rise = lo_s2_q & ~lo_d_q;

   // ****************************************
   // port arming
   // ****************************************
   logic armed_q; // port open for bits

   // reset reads the enable pin as low: a high level at release arms
   always_ff @(posedge clock) begin
      if (!resetn) begin
         armed_q <= 1'b0;
      end else if (!en_s2_q) begin
         armed_q <= 1'b0;
      end else if (en_rise) begin
         armed_q <= 1'b1;
      end
   end

   // ****************************************
   // bit queue between pins and shifter
   // ****************************************
   dwsp_state_t state_q; // sequencer state
   logic push_bit; // sampled bit offered
   logic fifo_in_ready; // queue has room
   logic fifo_out_valid; // queue holds a bit
   logic fifo_pop_ok; // shifter willing
   logic [FIFO_W-1:0] fifo_out; // next bit to shift

   // sample data on each port clock rise while armed
   assign push_bit = armed_q & en_s2_q & ck_rise;
   // shifter stalls while restoring or saving
   assign fifo_pop_ok = (state_q == DWSP_RUN);

   dwsp_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .resetn(resetn),
      .in_valid(push_bit),
      .in_ready(fifo_in_ready),
      .in_data(dt_s2_q),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop_ok),
      .out_data(fifo_out)
   );

   // room flag for the host side, a full queue drops bits
   always_ff @(posedge clock) begin
      if (!resetn) begin
         port_ready_q <= 1'b0;
      end else begin
         port_ready_q <= fifo_in_ready;
      end
   end

   // ****************************************
   // control sequencer
   // ****************************************
   logic [SAVE_CNT_W-1:0] save_cnt_q; // save cycles left
   logic restored_q; // restore load pending for wipers

   // restore after reset, run, save on falling supply
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q <= DWSP_RESTORE;
         save_cnt_q <= '0;
         restored_q <= 1'b0;
      end else begin
         // wipers also take the register the cycle after a restore
         restored_q <= (state_q == DWSP_RESTORE);
         case (state_q)
            DWSP_RESTORE: begin
               state_q <= DWSP_RUN;
            end
            DWSP_RUN: begin
               if (lo_rise) begin
                  state_q <= DWSP_SAVE;
                  save_cnt_q <= SAVE_CNT_W'(SAVE_LEN - 1);
               end
            end
            DWSP_SAVE: begin
               // once begun, a save runs to its end
               if (save_cnt_q == '0) begin
                  state_q <= DWSP_RUN;
               end else begin
                  save_cnt_q <= save_cnt_q - 1'b1;
               end
            end
            default: begin
               state_q <= DWSP_RUN;
            end
         endcase
      end
   end

   // ****************************************
   // serial shift register
   // ****************************************
   logic [SHIFT_LEN-1:0] shift_q; // the 17-stage register

   // new bits enter stage 0; after 17 the first sent sits
   // at the select position, pot one then pot zero below
   always_ff @(posedge clock) begin
      if (!resetn) begin
         shift_q <= SHIFT_RST;
      end else if (state_q == DWSP_RESTORE) begin
         shift_q <= nv_read_data;
      end else if (fifo_out_valid && fifo_pop_ok) begin
         shift_q <= {shift_q[LAST_STAGE-1:0], fifo_out[0]};
      end
   end

   // last stage is always visible, so read-back loops close
   always_ff @(posedge clock) begin
      if (!resetn) begin
         chain_data_output_q <= 1'b0;
      end else begin
         chain_data_output_q <= shift_q[LAST_STAGE];
      end
   end

   // ****************************************
   // apply to wipers on enable fall
   // ****************************************
   logic apply_pend_q; // fall seen, queue not drained yet
   logic apply_now; // load wipers this cycle

   // queued bits must land before the wipers take the value
   assign apply_now = apply_pend_q & ~fifo_out_valid & fifo_pop_ok;

   // a new fall wins over the clear of an older one
   always_ff @(posedge clock) begin
      if (!resetn) begin
         apply_pend_q <= 1'b0;
      end else if (en_fall) begin
         apply_pend_q <= 1'b1;
      end else if (apply_now) begin
         apply_pend_q <= 1'b0;
      end
   end

   // code ff is high end, 00 low end, passed through as is
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wiper_code_zero_q <= '0;
         wiper_code_one_q <= '0;
         stack_select_q <= 1'b0;
         stacked_code_q <= '0;
      end else if (apply_now || restored_q) begin
         // no length check: whatever is held goes out
         wiper_code_one_q <= shift_q[POT1_MSB:POT1_LSB];
         wiper_code_zero_q <= shift_q[POT0_MSB:POT0_LSB];
         stack_select_q <= shift_q[SEL_POS];
         stacked_code_q <= shift_q[SEL_POS] ?
            shift_q[POT1_MSB:POT1_LSB] :
            shift_q[POT0_MSB:POT0_LSB];
      end
   end

   // ****************************************
   // nonvolatile save port
   // ****************************************
   // no wear status is read: worn cells leave the port working
   always_ff @(posedge clock) begin
      if (!resetn) begin
         nv_write_en_q <= 1'b0;
         nv_write_data_q <= SHIFT_RST;
      end else begin
         nv_write_en_q <= (state_q == DWSP_SAVE);
         if (state_q == DWSP_RUN && lo_rise) begin
            nv_write_data_q <= shift_q;
         end
      end
   end
endmodule

// file: design/dwsp_pkg.sv
// ****************************************
// dual wiper serial port constants
// ****************************************
package dwsp_pkg;
   // shift register geometry
   localparam int SHIFT_LEN = 17; // stages in the serial register
   localparam int CODE_W = 8; // bits in one wiper code
   localparam int SEL_POS = 16; // stack select, first bit sent
   localparam int POT1_MSB = 15; // potentiometer one code, msb
   localparam int POT1_LSB = 8; // potentiometer one code, lsb
   localparam int POT0_MSB = 7; // potentiometer zero code, msb
   localparam int POT0_LSB = 0; // potentiometer zero code, lsb
   localparam int LAST_STAGE = 16; // stage feeding the chain output
   // buffering
   localparam int FIFO_DEPTH = 4; // bits queued between pins and shifter
   localparam int FIFO_W = 1; // one serial bit per word
   // timing
   localparam int CLK_PERIOD_NS = 25; // system clock period
   localparam int SAVE_TIME_US = 4000; // least power-down save time
   localparam int SAVE_CYCLES =
      (SAVE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAVE_CNT_W = 18; // wide enough for SAVE_CYCLES
   // reset value of the serial register before restore
   localparam logic [16:0] SHIFT_RST = 17'h00000;
   // control sequencer states
   typedef enum logic [1:0] {
      DWSP_RESTORE,
      DWSP_RUN,
      DWSP_SAVE
   } dwsp_state_t;
endpackage

// file: bench/dwsp_port_asserts.sv
`timescale 1ns/10ps
// ****
// port checker
// ****
module dwsp_port_asserts
   import dwsp_pkg::*;
#(
   parameter int SAVE_LEN = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // serial pins
   input wire logic port_enable,
   input wire logic port_clock,
   input wire logic port_data,
   input wire logic chain_data_output_q,
   input wire logic port_ready_q,
   // wiper controls
   input wire logic [dwsp_pkg::CODE_W-1:0] wiper_code_zero_q,
   input wire logic [dwsp_pkg::CODE_W-1:0] wiper_code_one_q,
   input wire logic stack_select_q,
   input wire logic [dwsp_pkg::CODE_W-1:0] stacked_code_q,
   // supply and nv copy
   input wire logic supply_low,
   input wire logic [dwsp_pkg::SHIFT_LEN-1:0] nv_read_data,
   input wire logic nv_write_en_q,
   input wire logic [dwsp_pkg::SHIFT_LEN-1:0] nv_write_data_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [16:0] app; // applied image
   logic [16:0] prev_q; // image one cycle ago
   logic [3:0] idle_q; // quiet cycles, saturating
   int save_cnt_q; // cycles of the running save
   assign app = {stack_select_q, wiper_code_one_q, wiper_code_zero_q};
   // history of the applied image
   always_ff @(posedge clock) begin
      prev_q <= app;
   end
   // quiet time: shifting may drain late, so wait a margin
   always_ff @(posedge clock) begin
      if (!resetn || port_enable || nv_write_en_q) begin
         idle_q <= 4'h0;
      end else if (idle_q != 4'hf) begin
         idle_q <= idle_q + 4'h1;
      end
   end
   // save pulse length
   always_ff @(posedge clock) begin
      if (!resetn || !nv_write_en_q) begin
         save_cnt_q <= 0;
      end else begin
         save_cnt_q <= save_cnt_q + 1;
      end
   end
   a_stack_mux: assert property ((app == prev_q)[*2] |->
      stacked_code_q ==
      (stack_select_q ? wiper_code_one_q : wiper_code_zero_q))
      else $error("stacked code wrong");
   a_wiper_hold: assert property (app != prev_q |->
      !$past(port_enable, 3))
      else $error("wipers moved with enable high");
   a_idle_chain: assert property (idle_q >= 4'he |->
      $stable(chain_data_output_q))
      else $error("chain moved while port idle");
   a_power_restore: assert property ($rose(resetn) |-> ##[2:3]
      (app == nv_read_data && chain_data_output_q == nv_read_data[16]))
      else $error("restore image wrong");
   a_save_start: assert property ($rose(supply_low) |->
      ##[2:8] $rose(nv_write_en_q))
      else $error("save not started");
   a_save_length: assert property ($fell(nv_write_en_q) |->
      save_cnt_q == SAVE_LEN)
      else $error("save length wrong");
   a_save_data: assert property ($rose(nv_write_en_q) |->
      nv_write_data_q == app)
      else $error("saved image wrong");
   a_save_hold: assert property (nv_write_en_q &&
      $past(nv_write_en_q) |-> $stable(nv_write_data_q))
      else $error("saved image moved");
   c_restore: cover property ($rose(resetn) ##3 1);
   c_save: cover property ($fell(nv_write_en_q));
   c_full: cover property (!port_ready_q ##1 port_ready_q);
endmodule
bind dwsp_port dwsp_port_asserts #(.SAVE_LEN(SAVE_LEN)) chk_u (
   .clock(clock), .resetn(resetn), .port_enable(port_enable),
   .port_clock(port_clock), .port_data(port_data),
   .chain_data_output_q(chain_data_output_q), .port_ready_q(port_ready_q),
   .wiper_code_zero_q(wiper_code_zero_q),
   .wiper_code_one_q(wiper_code_one_q), .stack_select_q(stack_select_q),
   .stacked_code_q(stacked_code_q), .supply_low(supply_low),
   .nv_read_data(nv_read_data), .nv_write_en_q(nv_write_en_q),
   .nv_write_data_q(nv_write_data_q));

// file: bench/dwsp_host.sv
`timescale 1ns/10ps
// ****
// host side of the serial chain
// ****
module dwsp_host (
   // pacing clock
   input wire logic clock,
   // serial pins
   output logic port_enable,
   output logic port_clock,
   output logic port_data,
   input wire logic chain_data_output_q
);
   logic data_q; // bit the host drives
   logic loop_q; // host lets go, chain feeds back
   logic [33:0] seen; // chain bits seen before each rise
   assign port_data = loop_q ? chain_data_output_q : data_q;
   // idle pins at time zero, serial clock still
   initial begin
      port_enable = 1'b0;
      port_clock = 1'b0;
      data_q = 1'b0;
      loop_q = 1'b0;
      seen = '0;
   end
   // n cycles, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   // n bits, msb first; en low makes stray edges only
   task automatic xfer(input logic [33:0] bits, input int n,
                       input logic loop, input logic en, input int half);
      loop_q = loop;
      tick(1);
      port_enable = en;
      tick(8);
      for (int i = n - 1; i >= 0; i--) begin
         data_q = bits[i];
         tick(half);
         seen = {seen[32:0], chain_data_output_q};
         port_clock = 1'b1;
         tick(half);
         port_clock = 1'b0;
      end
      tick(8);
      port_enable = 1'b0;
      loop_q = 1'b0;
      data_q = ~data_q;
      tick(12);
   endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, a) check(nm, e, a)
module tb;
   import dwsp_pkg::*;
   localparam logic [16:0] NV_IMG = 17'h1a55c; // image saved before power-up
   logic clock, resetn, supply_low, saw_full;
   logic port_enable, port_clock, port_data, chain_data_output_q;
   logic port_ready_q, stack_select_q, nv_write_en_q;
   logic [CODE_W-1:0] wz, wo, stk;
   logic [16:0] nv_write_data_q, img_q, app, nv_img;
   int n_fail, compares;
   assign app = {stack_select_q, wo, wz};
   // long save so the bit queue fills
   dwsp_port #(.SAVE_LEN(200)) dut_u (.clock(clock), .resetn(resetn),
      .port_enable(port_enable), .port_clock(port_clock),
      .port_data(port_data), .chain_data_output_q(chain_data_output_q),
      .port_ready_q(port_ready_q), .wiper_code_zero_q(wz),
      .wiper_code_one_q(wo), .stack_select_q(stack_select_q),
      .stacked_code_q(stk), .supply_low(supply_low),
      .nv_read_data(nv_img), .nv_write_en_q(nv_write_en_q),
      .nv_write_data_q(nv_write_data_q));
   dwsp_host host_u (.clock(clock), .port_enable(port_enable),
      .port_clock(port_clock), .port_data(port_data),
      .chain_data_output_q(chain_data_output_q));
   task automatic check(input string nm, input logic [16:0] e,
                        input logic [16:0] a);
      compares++;
      if (a !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, a);
      end
   endtask
   task automatic complete_run;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // applied image and stacked code against img
   task automatic expect_img(input logic [16:0] img);
      `CHK("image", img, app);
      `CHK("stacked", 17'(img[16] ? img[15:8] : img[7:0]), 17'(stk));
      img_q = img;
   endtask
   // power-up: register, wipers and chain come back from the saved image
   task automatic t_restore(input logic [16:0] img);
      nv_img = img;
      resetn = 1'b0;
      repeat (20) @(posedge clock);
      #2;
      resetn = 1'b1;
      repeat (8) @(posedge clock);
      #2;
      `CHK("restore", img, app);
      `CHK("restore chain", 17'(img[16]), 17'(chain_data_output_q));
      img_q = img;
   endtask
   // one full write, old image read out on the chain
   task automatic t_write(input logic [16:0] img, input int half);
      host_u.xfer(34'(img), 17, 1'b0, 1'b1, half);
      `CHK("chain out", img_q, host_u.seen[16:0]);
      expect_img(img);
   endtask
   // two images back to back, as for two chained parts
   task automatic t_chain;
      host_u.xfer({17'h0e1c3, 17'h13c5a}, 34, 1'b0, 1'b1, 4);
      `CHK("chain old", img_q, host_u.seen[33:17]);
      `CHK("chain first", 17'h0e1c3, host_u.seen[16:0]);
      expect_img(17'h13c5a);
   endtask
   // stray edges with enable low, then read-back loop
   task automatic t_idle_readback;
      host_u.xfer(34'h15555, 17, 1'b0, 1'b0, 4);
      `CHK("stray", img_q, app);
      host_u.xfer(34'h0, 17, 1'b1, 1'b1, 4);
      `CHK("read back", img_q, host_u.seen[16:0]);
      expect_img(img_q);
   endtask
   // short transfer applied as it stands
   task automatic t_short;
      host_u.xfer(34'h15, 5, 1'b0, 1'b1, 4);
      expect_img({img_q[11:0], 5'h15});
   endtask
   // save, with bits sent meanwhile until the queue refuses
   task automatic t_save;
      supply_low = 1'b1;
      for (int i = 0; i < 20 && nv_write_en_q !== 1'b1; i++) begin
         host_u.tick(1);
      end
      `CHK("save began", 17'h1, 17'(nv_write_en_q));
      `CHK("saved", img_q, nv_write_data_q);
      host_u.xfer(34'h0b0f0, 17, 1'b0, 1'b1, 4);
      for (int i = 0; i < 300 && nv_write_en_q !== 1'b0; i++) begin
         host_u.tick(1);
      end
      `CHK("save ended", 17'h0, 17'(nv_write_en_q));
      supply_low = 1'b0;
      repeat (20) @(posedge clock);
      `CHK("queue full", 17'h1, 17'(saw_full));
      expect_img({img_q[12:0], 4'h5});
   endtask
   // queue refusal seen at the ready flag, only while a save runs
   always @(posedge clock) begin
      if (nv_write_en_q === 1'b1 && port_ready_q === 1'b0) begin
         saw_full <= 1'b1;
      end
   end
   // system clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // main sequence
   initial begin
      resetn = 1'b0;
      supply_low = 1'b0;
      saw_full = 1'b0;
      n_fail = 0;
      compares = 0;
      t_restore(NV_IMG);
      t_write(17'h1ff00, 4);
      t_write(17'h000ff, 4);
      t_write(17'h0c35a, 4);
      t_chain();
      t_idle_readback();
      t_short();
      t_save();
      // mid-run power cycle brings back what was saved
      t_restore(nv_write_data_q);
      t_idle_readback();
      complete_run();
   end
   // watchdog well past the expected run
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
endmodule
